// >>> hdl/e3m_rx_monitor.sv
// E3 receive alarm and overhead monitor with register port
`include "e3m_consts.svh"
module e3m_rx_monitor
#(
    parameter int FRAME_BITS = `E3M_FRAME_BITS
)
(
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       rx_line_clk,
    input  wire logic       rx_positive_rail,
    input  wire logic       rx_negative_rail,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wr_data,
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    output logic      [7:0] reg_rd_data,
    output logic            irq
);
    e3m_pkg::e3m_bit_t   lbit;
    e3m_pkg::e3m_frm_t   state_q;
    e3m_pkg::e3m_ma_t    ma;
    e3m_pkg::e3m_alarm_t cur;
    e3m_pkg::e3m_alarm_t prev_q;
    logic [15:0] sr_q;
    logic [15:0] sr_d;
    logic [12:0] pos_q;
    logic [2:0]  err_cnt_q;
    logic        realign_q;
    logic        pos_wrap;
    logic        fa_chk;
    logic        frame_end;
    logic        ma_cap;
    logic        lock_hit;
    logic [4:0]  lof_cnt_q;
    logic        lof_q;
    logic [5:0]  zrun_q;
    logic        los_q;
    logic [2:0]  zcnt_q;
    logic [2:0]  zc_now;
    logic        few_prev_q;
    logic        ais_q;
    logic [2:0]  ptype_q;
    logic [2:0]  stab_q;
    logic [2:0]  stab_d;
    logic        unstab_q;
    logic        mis_ev_q;
    logic        ferf_state;
    logic        tmark_state;
    logic [2:0]  exp_q;
    logic        ferf_sel_q;
    logic        tmark_sel_q;
    logic        lof_algo_q;
    logic [6:0]  ien1_q;
    logic [6:0]  ien_eff;
    logic        rev98_q;
    logic        mis_en_q;
    logic [6:0]  ev;
    logic [6:0]  isr1_q;
    logic        isr2_q;
    logic        rd_clr1;
    logic        rd_clr2;

    // Saturating increment used by the zero and stability counters
    function automatic logic [2:0] inc_sat(input logic [2:0] v, input logic [2:0] lim);
        inc_sat = (v >= lim) ? lim : v + 3'h1;
    endfunction

    e3m_line_sync u_sync
    (
        .core_clk         (core_clk),
        .srst             (srst),
        .rx_line_clk      (rx_line_clk),
        .rx_positive_rail (rx_positive_rail),
        .rx_negative_rail (rx_negative_rail),
        .line_bit         (lbit)
    );

    // Frame position decode
    assign sr_d      = {sr_q[14:0], lbit.data};
    assign pos_wrap  = (pos_q == 13'(FRAME_BITS - 1));
    assign fa_chk    = lbit.valid && state_q == e3m_pkg::E3M_LOCK && pos_q == `E3M_FA_LAST_BIT;
    assign frame_end = lbit.valid && pos_wrap;
    assign ma_cap    = lbit.valid && state_q == e3m_pkg::E3M_LOCK && pos_q == `E3M_MA_LAST_BIT;
    assign ma        = e3m_pkg::e3m_ma_t'(sr_d[7:0]);
    assign lock_hit  = lbit.valid && state_q == e3m_pkg::E3M_HUNT && sr_d == `E3M_FA_PATTERN;

    // Framer: hunt for the alignment word, then check it once a frame
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_q   <= e3m_pkg::E3M_HUNT;
            pos_q     <= 13'h0;
            sr_q      <= 16'h0;
            err_cnt_q <= 3'h0;
            realign_q <= 1'b0;
        end
        else
        begin
            realign_q <= 1'b0;
            if (lbit.valid)
            begin
                sr_q  <= sr_d;
                pos_q <= pos_wrap ? 13'h0 : pos_q + 13'h1;
                if (state_q == e3m_pkg::E3M_HUNT)
                begin
                    if (sr_d == `E3M_FA_PATTERN)
                    begin
                        state_q   <= e3m_pkg::E3M_LOCK;
                        pos_q     <= `E3M_FA_LAST_BIT + 13'h1;
                        err_cnt_q <= 3'h0;
                        realign_q <= 1'b1;
                    end
                end
                else if (fa_chk)
                begin
                    if (sr_d == `E3M_FA_PATTERN)
                        err_cnt_q <= 3'h0;
                    else if (err_cnt_q == `E3M_OOF_FRAMES - 3'h1)
                    begin
                        state_q   <= e3m_pkg::E3M_HUNT;
                        err_cnt_q <= 3'h0;
                    end
                    else
                        err_cnt_q <= err_cnt_q + 3'h1;
                end
            end
        end
    end

    // Loss of frame: whole periods counted from the OOF bit; select does not change the count
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            lof_cnt_q <= 5'h0;
            lof_q     <= 1'b1;
        end
        else if (state_q == e3m_pkg::E3M_LOCK || lock_hit)   // Clears with the lock, never after
        begin
            lof_cnt_q <= 5'h0;
            lof_q     <= 1'b0;
        end
        else if (lbit.valid && pos_q == `E3M_FA_LAST_BIT && !lof_q)
        begin
            if (lof_cnt_q == `E3M_LOF_FRAMES - 5'h1)
                lof_q <= 1'b1;
            else
                lof_cnt_q <= lof_cnt_q + 5'h1;
        end
    end

    // Loss of signal: run of zeros on both rails; any pulse ends it
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            zrun_q <= 6'h0;
            los_q  <= 1'b1;
        end
        else if (lbit.valid)
        begin
            if (lbit.data)
            begin
                zrun_q <= 6'h0;
                los_q  <= 1'b0;
            end
            else if (zrun_q == `E3M_LOS_ZEROS - 6'h1)
                los_q <= 1'b1;
            else
                zrun_q <= zrun_q + 6'h1;
        end
    end

    // AIS: zeros per frame, counted only up to the threshold
    assign zc_now = (lbit.valid && !lbit.data) ? inc_sat(zcnt_q, `E3M_AIS_ZEROS) : zcnt_q;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            zcnt_q     <= 3'h0;
            few_prev_q <= 1'b0;
            ais_q      <= 1'b1;
        end
        else if (frame_end)
        begin
            zcnt_q     <= 3'h0;
            few_prev_q <= zc_now < `E3M_AIS_ZEROS;
            if (zc_now >= `E3M_AIS_ZEROS)
                ais_q <= 1'b0;
            else if (few_prev_q)
                ais_q <= 1'b1;
        end
        else
            zcnt_q <= zc_now;
    end

    // Payload type capture, stability and mismatch
    assign stab_d = (ma.ptype != ptype_q) ? 3'h0 : inc_sat(stab_q, `E3M_UNSTAB_FRAMES);

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ptype_q  <= 3'h0;
            stab_q   <= 3'h0;
            unstab_q <= 1'b1;
            mis_ev_q <= 1'b0;
        end
        else
        begin
            mis_ev_q <= ma_cap && ma.ptype != exp_q;
            if (ma_cap)
            begin
                ptype_q  <= ma.ptype;
                stab_q   <= stab_d;
                unstab_q <= stab_d < `E3M_UNSTAB_FRAMES;
            end
        end
    end

    // Far-end failure filter, 3 or 5 frames
    e3m_persist #(.RST_STATE(1'b1)) u_ferf
    (
        .core_clk (core_clk),
        .srst     (srst),
        .strobe   (ma_cap),
        .sample   (ma.ferf),
        .long_sel (ferf_sel_q),
        .state_q  (ferf_state)
    );

    // Timing marker filter; the later revision always uses the short count
    e3m_persist #(.RST_STATE(1'b1)) u_tmark
    (
        .core_clk (core_clk),
        .srst     (srst),
        .strobe   (ma_cap),
        .sample   (ma.tmark),
        .long_sel (tmark_sel_q & ~rev98_q),
        .state_q  (tmark_state)
    );

    // Configuration writes
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            {ferf_sel_q, tmark_sel_q, exp_q} <= 5'(`E3M_RST_CFG1);
            lof_algo_q <= 1'(`E3M_RST_CFG2 >> 7);
            ien1_q     <= `E3M_RST_IEN1;
            {mis_en_q, rev98_q} <= 2'h0;
        end
        else if (reg_wr_en)
        begin
            case (reg_addr)
                `E3M_OFS_CFG1: {ferf_sel_q, tmark_sel_q, exp_q} <= reg_wr_data[4:0];
                `E3M_OFS_CFG2: lof_algo_q <= reg_wr_data[7];
                `E3M_OFS_IEN1: ien1_q <= reg_wr_data[6:0];
                `E3M_OFS_AUX:  {rev98_q, mis_en_q} <= reg_wr_data[1:0];
                default: ;
            endcase
        end
    end

    // Change detection; sync status events have no source in this channel
    assign cur = '{lof: lof_q, oof: state_q == e3m_pkg::E3M_HUNT, los: los_q, ais: ais_q};
    assign ev  = {2'b00, realign_q, cur.oof ^ prev_q.oof, cur.lof ^ prev_q.lof,
                  cur.los ^ prev_q.los, cur.ais ^ prev_q.ais};
    assign rd_clr1 = reg_rd_en && reg_addr == `E3M_OFS_ISR1;
    assign rd_clr2 = reg_rd_en && reg_addr == `E3M_OFS_ISR2;
    assign ien_eff = rev98_q ? ien1_q : ien1_q & ~`E3M_SSM_EN_MASK;

    // Sticky status; a new event in the clearing cycle survives the read
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            prev_q <= '1;
            isr1_q <= 7'h0;
            isr2_q <= 1'b0;
        end
        else
        begin
            prev_q <= cur;
            isr1_q <= (rd_clr1 ? 7'h0 : isr1_q) | ev;
            isr2_q <= (rd_clr2 ? 1'b0 : isr2_q) | mis_ev_q;
        end
    end

    // Interrupt request from latched and enabled bits
    always_ff @(posedge core_clk)
    begin
        if (srst)
            irq <= 1'b0;
        else
            irq <= |(isr1_q & ien_eff) | (isr2_q & mis_en_q);
    end

    // Read data, one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge core_clk)
    begin
        if (srst)
            reg_rd_data <= 8'h0;
        else if (reg_rd_en)
        begin
            case (reg_addr)
                `E3M_OFS_CFG1: reg_rd_data <= {ptype_q, ferf_sel_q, tmark_sel_q, exp_q};
                `E3M_OFS_CFG2: reg_rd_data <= {lof_algo_q, lof_q, cur.oof, los_q, ais_q,
                                               unstab_q, tmark_state, ferf_state};
                `E3M_OFS_IEN1: reg_rd_data <= {1'b0, ien1_q};
                `E3M_OFS_ISR1: reg_rd_data <= {1'b0, isr1_q};
                `E3M_OFS_ISR2: reg_rd_data <= {7'h0, isr2_q};
                `E3M_OFS_AUX:  reg_rd_data <= {6'h0, rev98_q, mis_en_q};
                default:       reg_rd_data <= 8'h0;
            endcase
        end
        else
            reg_rd_data <= 8'h0;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_fa_fail_last;
        fa_chk && sr_d != `E3M_FA_PATTERN && err_cnt_q == 3'h3;
    endsequence

    a_los_declare: assert property
        (lbit.valid && !lbit.data && zrun_q == 6'd31 |=> los_q)
        else $error("LOS not declared after 32 zeros");
    a_los_clear: assert property (lbit.valid && lbit.data |=> !los_q)
        else $error("LOS held after a one");
    a_oof_declare: assert property
        (s_fa_fail_last |=> state_q == e3m_pkg::E3M_HUNT)
        else $error("OOF not declared after four bad frames");
    a_lof_needs_oof: assert property (lof_q |-> cur.oof)
        else $error("LOF without OOF");
    a_change_latch: assert property ($changed(cur.los) |=> isr1_q[1])
        else $error("LOS change not latched");
    a_read_clear: assert property (rd_clr1 && ev == 7'h0 |=> isr1_q == 7'h0)
        else $error("status not cleared by read");
    a_mismatch_event: assert property
        (ma_cap && ma.ptype != exp_q |=> ##1 isr2_q)
        else $error("payload mismatch not latched");
    a_irq_raise: assert property ((isr1_q & ien_eff) != 7'h0 |=> irq)
        else $error("interrupt not raised");
    a_ssm_masked: assert property
        (!rev98_q && isr1_q[4:0] == 5'h0 && !isr2_q |=> !irq)
        else $error("sync status enable honoured in 1995 mode");
endmodule

// >>> pkg/e3m_consts.svh
// Offsets, field positions, reset values and frame counts of the E3 receive alarm monitor
// How it works
// - Far-end failure select 1: declare or clear after 5 equal frames.
// - Far-end failure select 0: declare or clear after 3 equal frames.
// - Far-end failure status bit shows the filtered far-end failure state.
// - Timing marker accepted after 3 or 5 unchanged frames, per its select.
// - Validated timing marker appears at bit 1 of register 0x11.
// - The 1998 framing revision ignores the timing-marker select, using 3 frames.
// - Received payload type differing from expected raises a mismatch event.
// - Latest received payload type reads in bits 7 to 5 of 0x10.
// - LOF declared after 24 frame periods of OOF, with either select value.
// - LOF status bit is 1 while the framer is in loss of frame.
// - OOF declared after four consecutive frames with framing byte errors.
// - LOS declared after 32 consecutive zeros on both receive rails.
// - AIS declared after two consecutive frames each holding under seven zeros.
// - Payload unstable is 1 if the type changed within the last 5 frames.
// - Bits 6 to 0 of the event enable register gate their events.
// - OOF, LOF, LOS and AIS events fire on every change of the condition.
// - The 1995 framing revision ignores both sync status message enables.
// - Each event latches a status bit; reading the status register clears it.
`ifndef E3M_CONSTS_SVH
`define E3M_CONSTS_SVH
`define E3M_OFS_CFG1 8'h10
`define E3M_OFS_CFG2 8'h11
`define E3M_OFS_IEN1 8'h12
`define E3M_OFS_ISR1 8'h14
`define E3M_OFS_ISR2 8'h15
`define E3M_OFS_AUX 8'h16
`define E3M_RST_CFG1 8'h00
`define E3M_RST_CFG2 8'h7f
`define E3M_RST_IEN1 7'h00
`define E3M_SSM_EN_MASK 7'h60
`define E3M_FA_PATTERN 16'hf628
`define E3M_FA_LAST_BIT 13'd15
`define E3M_MA_LAST_BIT 13'd39
`define E3M_FRAME_BITS 4296
`define E3M_OOF_FRAMES 3'd4
`define E3M_LOF_FRAMES 5'd24
`define E3M_LOS_ZEROS 6'd32
`define E3M_AIS_ZEROS 3'd7
`define E3M_UNSTAB_FRAMES 3'd5
`define E3M_PERSIST_SHORT 3'd3
`define E3M_PERSIST_LONG 3'd5
`endif

// >>> pkg/e3m_pkg.sv
// Types shared by the E3 receive alarm monitor
package e3m_pkg;
    // One recovered line bit, valid for one core cycle
    typedef struct packed
    {
        logic valid;
        logic data;
    } e3m_bit_t;

    // Overhead status byte, first received bit in the msb
    typedef struct packed
    {
        logic       ferf;
        logic       febe;
        logic [2:0] ptype;
        logic [1:0] sync_status_message;
        logic       tmark;
    } e3m_ma_t;

    typedef struct packed
    {
        logic lof;
        logic oof;
        logic los;
        logic ais;
    } e3m_alarm_t;

    typedef enum logic
    {
        E3M_HUNT = 1'b0,
        E3M_LOCK = 1'b1
    } e3m_frm_t;
endpackage

// >>> hdl/e3m_line_sync.sv
// Line clock and rail synchroniser with bit recovery
module e3m_line_sync
(
    input  wire logic             core_clk,
    input  wire logic             srst,
    input  wire logic             rx_line_clk,
    input  wire logic             rx_positive_rail,
    input  wire logic             rx_negative_rail,
    output e3m_pkg::e3m_bit_t     line_bit
);
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic       clk_prev_q;

    // Two-stage capture of clock and rails together, so rails keep their phase
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
        end
        else
        begin
            meta_q <= {rx_line_clk, rx_positive_rail, rx_negative_rail};
            sync_q <= meta_q;
        end
    end

    // Rising line clock edge; a pulse on either rail is a one
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            clk_prev_q <= 1'b0;
            line_bit   <= '0;
        end
        else
        begin
            clk_prev_q     <= sync_q[2];
            line_bit.valid <= sync_q[2] & ~clk_prev_q;
            line_bit.data  <= sync_q[1] | sync_q[0];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    a_bit_single_pulse: assert property (line_bit.valid |=> !line_bit.valid)
        else $error("line bit strobe longer than one cycle");
endmodule

// >>> hdl/e3m_persist.sv
// Consecutive-frame persistence filter with 3 or 5 frame select
`include "e3m_consts.svh"
module e3m_persist
#(
    parameter logic RST_STATE = 1'b1
)
(
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic strobe,
    input  wire logic sample,
    input  wire logic long_sel,
    output logic      state_q
);
    logic [2:0] run_q;
    logic [2:0] need;

    assign need = long_sel ? `E3M_PERSIST_LONG : `E3M_PERSIST_SHORT;

    // Counts frames disagreeing with the state; one agreeing frame restarts it
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_q <= RST_STATE;
            run_q   <= 3'h0;
        end
        else if (strobe)
        begin
            if (sample == state_q)
                run_q <= 3'h0;
            else if (run_q + 3'h1 >= need)
            begin
                state_q <= sample;
                run_q   <= 3'h0;
            end
            else
                run_q <= run_q + 3'h1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // First disagreeing frame after an agreeing one
    sequence s_first_differ;
        strobe && sample != state_q && run_q == 3'h0;
    endsequence

    a_persist_on_strobe: assert property ($changed(state_q) |-> $past(strobe))
        else $error("persistence state moved without a frame");
    a_persist_not_early: assert property (s_first_differ |=> $stable(state_q))
        else $error("persistence state moved after one frame");
endmodule

// >>> test/e3m_line_model.sv
// Line interface model that drives the receive rails with a gated line clock
module e3m_line_model
(
    output logic line_clk,
    output logic pos_rail,
    output logic neg_rail
);
    timeunit 1ns;
    timeprecision 100ps;

    logic mark_q = 1'b0;

    // Idle levels at time zero
    initial
    begin
        line_clk = 1'b0;
        pos_rail = 1'b0;
        neg_rail = 1'b0;
    end

    // Sends n bits msb first, marks alternate between rails; clock stands still between bursts
    task automatic send(input logic [47:0] bits, input int n);
        #1.5;
        for (int i = n - 1; i >= 0; i--)
        begin
            pos_rail = bits[i] & ~mark_q;
            neg_rail = bits[i] & mark_q;
            mark_q = mark_q ^ bits[i];
            #40 line_clk = 1'b1;
            #40 line_clk = 1'b0;
        end
        // Rails are not held after a burst, so a stale level must not look valid
        pos_rail = ~pos_rail;
        neg_rail = ~neg_rail;
    endtask
endmodule

// >>> test/e3m_rx_monitor_tb.sv
// Self-checking bench for the E3 receive alarm and overhead monitor
module e3m_rx_monitor_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int FB = 48;  // Shortest legal frame keeps the run brief

    logic       core_clk = 1'b0;
    logic       srst = 1'b1;
    logic       rx_line_clk;
    logic       rx_positive_rail;
    logic       rx_negative_rail;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wr_data = 8'h00;
    logic       reg_wr_en = 1'b0;
    logic       reg_rd_en = 1'b0;
    logic [7:0] reg_rd_data;
    logic       irq;
    int         mismatches = 0;
    int         samples_checked = 0;
    // Reference model state
    logic [2:0] exp_pt;
    logic [2:0] pt = 3'h0;
    logic [6:0] en;
    logic [6:0] ev = 7'h00;
    logic [7:0] d;
    logic [7:0] ma;
    logic       fsel = 1'b0, tsel = 1'b0, rev = 1'b0, lofsel = 1'b0, mis = 1'b0;
    logic       lof = 1'b1, oof = 1'b1, los = 1'b1, ais = 1'b1, uns = 1'b1;
    logic       tm = 1'b1, ferf = 1'b1;
    int         fr = 0, tr = 0, same = 0;

    always #2 core_clk = ~core_clk;

    e3m_rx_monitor
    #(
        .FRAME_BITS (FB)
    )
    u_e3m_rx_monitor
    (
        .core_clk         (core_clk),
        .srst             (srst),
        .rx_line_clk      (rx_line_clk),
        .rx_positive_rail (rx_positive_rail),
        .rx_negative_rail (rx_negative_rail),
        .reg_addr         (reg_addr),
        .reg_wr_data      (reg_wr_data),
        .reg_wr_en        (reg_wr_en),
        .reg_rd_en        (reg_rd_en),
        .reg_rd_data      (reg_rd_data),
        .irq              (irq)
    );

    e3m_line_model u_e3m_line_model
    (
        .line_clk (rx_line_clk),
        .pos_rail (rx_positive_rail),
        .neg_rail (rx_negative_rail)
    );

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] want);
        samples_checked++;
        if (got !== want)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h want=%h", $time, got, want);
        end
    endtask

    task automatic cmp_irq(input logic want);
        #1;
        samples_checked++;
        if (irq !== want)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h want=%h", $time, irq, want);
        end
    endtask

    // Register port: one-cycle strobes, read data valid in the next cycle only
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wr_data <= v;
        reg_wr_en <= 1'b1;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        #1 v = reg_rd_data;
    endtask

    task automatic rd_cmp(input logic [7:0] a, input logic [7:0] want);
        rd(a, d);
        cmp8(d, want);
    endtask

    // Settling time covers the bit recovery and the status update latency
    task automatic gap();
        repeat (10) @(posedge core_clk);
    endtask

    task automatic frame(input logic [15:0] fa, input logic [7:0] oh);
        u_e3m_line_model.send({fa, 16'h5555, oh, 8'h55}, FB);
        gap();
    endtask

    // Flips the state once n frames in a row disagree with it
    function automatic logic filt(input logic st, input logic b, input int n, inout int run);
        run = (b === st) ? 0 : run + 1;
        if (run < n)
            return st;
        run = 0;
        return b;
    endfunction

    task automatic model_frame(input logic [7:0] oh);
        ferf = filt(ferf, oh[7], fsel ? 5 : 3, fr);
        tm = filt(tm, oh[0], (tsel && !rev) ? 5 : 3, tr);
        same = (oh[5:3] !== pt) ? 0 : same + 1;
        uns = (same >= 5) ? 1'b0 : (oh[5:3] !== pt) ? 1'b1 : uns;
        pt = oh[5:3];
        mis = mis | (pt !== exp_pt);
    endtask

    task automatic check_all();
        cmp_irq(|(ev & en) | mis);
        rd(8'h11, d);
        cmp8(d, {lofsel, lof, oof, los, ais, uns, tm, ferf});
        rd_cmp(8'h10, {pt, fsel, tsel, exp_pt});
        rd_cmp(8'h15, {7'h00, mis});
        mis = 1'b0;
    endtask

    task automatic check_ev();
        rd_cmp(8'h14, {1'b0, ev});
        ev = 7'h00;
    endtask

    // Watchdog against a hung run
    initial
    begin
        repeat (100000) @(posedge core_clk);
        mismatches++;
        conclude();
    end

    // Main sequence
    initial
    begin
        void'($urandom(32'hef536b4b));
        exp_pt = 3'($urandom);
        en = 7'($urandom);
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        rd_cmp(8'h11, 8'h7f);
        rd_cmp(8'h10, 8'h00);
        rd_cmp(8'h12, 8'h00);
        rd_cmp(8'h20, 8'h00);
        wr(8'h11, 8'h80);
        lofsel = 1'b1;
        rd_cmp(8'h11, 8'hff);
        wr(8'h10, 8'hff);
        rd_cmp(8'h10, 8'h1f);
        wr(8'h10, {3'h0, 2'b10, exp_pt});
        fsel = 1'b1;
        wr(8'h12, {1'b0, en});
        rd_cmp(8'h12, {1'b0, en});
        wr(8'h16, 8'h01);
        $display("test registers done");
        // Lock and let all but the far-end failure alarm clear; clears count as events too
        repeat (7) frame(16'hf628, {2'b10, exp_pt, 3'b001});
        {lof, oof, los, ais, uns} = 5'h00;
        pt = exp_pt;
        ev = 7'h1f;
        check_all();
        check_ev();
        $display("test lock done");
        // Persistence counts at their boundaries, mismatch, unstable payload
        for (int i = 0; i < 10; i++)
        begin
            if (i == 5)
            begin
                wr(8'h16, 8'h03);
                rev = 1'b1;
            end
            if (i == 6)
            begin
                wr(8'h10, {3'h0, 2'b01, exp_pt});
                fsel = 1'b0;
                tsel = 1'b1;
            end
            ma = {i >= 6, 1'b0, (i == 3) ? exp_pt ^ 3'h1 : exp_pt, 2'b00, i >= 6};
            frame(16'hf628, ma);
            model_frame(ma);
            check_all();
        end
        $display("test overhead done");
        // Bad alignment words: out of frame after four, loss of frame 24 periods later
        for (int k = 1; k <= 28; k++)
        begin
            frame(16'haaaa, 8'h00);
            if (k < 4)
                model_frame(8'h00);
            if (k == 4)
                {oof, ev[3]} = 2'b11;
            if (k == 28)
                {lof, ev[2]} = 2'b11;
            check_all();
            if (k == 4 || k == 28)
                check_ev();
        end
        $display("test framing done");
        // One zero short of signal loss, then the deciding zero
        u_e3m_line_model.send(48'h0, 31);
        gap();
        check_all();
        u_e3m_line_model.send(48'h0, 1);
        gap();
        {los, ev[1]} = 2'b11;
        check_all();
        check_ev();
        // All-ones frames: signal returns, alarm indication declared
        repeat (3) u_e3m_line_model.send(48'hffff_ffff_ffff, FB);
        gap();
        {los, ais, ev[1:0]} = 4'b0111;
        check_all();
        check_ev();
        $display("test alarms done");
        conclude();
    end
endmodule
